// file: hdl/cgd_defs.svh
// cgd_defs.svh: offsets, field positions, reset values and counts of the
// clock generator. Included by the package, the top design file and bench.
`ifndef CGD_DEFS_SVH
`define CGD_DEFS_SVH

`define CGD_ADDR_W 3
`define CGD_DATA_W 8

// register offsets, one byte each
`define CGD_OFS_PLL_CTRL 3'h0
`define CGD_OFS_PLL_BW 3'h1
`define CGD_OFS_PLL_MULT 3'h2
`define CGD_OFS_PLL_REF 3'h3
`define CGD_OFS_VCO_RANGE 3'h4
`define CGD_OFS_VCO_LIN 3'h5
`define CGD_OFS_ADC_CLK 3'h6
`define CGD_OFS_CONFIG 3'h7

// pll control fields
`define CGD_BIT_IRQ_EN 7
`define CGD_BIT_IRQ_FLAG 6
`define CGD_BIT_PLL_ON 5
`define CGD_BIT_BASE_SEL 4
`define CGD_POS_PRESCALE 0
// bandwidth fields
`define CGD_BIT_AUTO 7
`define CGD_BIT_LOCK 6
`define CGD_BIT_ACQ 5
// converter clock fields
`define CGD_POS_ADC_DIV 5
`define CGD_BIT_ADC_ISEL 4
// configuration and status fields
`define CGD_BIT_OSC_KEEP 0
`define CGD_BIT_ADC_SRC_NOW 1
`define CGD_BIT_BASE_SRC_NOW 2

// reset values
`define CGD_RST_PLL_CTRL 8'h00
`define CGD_RST_PLL_BW 8'h80
`define CGD_RST_MULT 8'h01
`define CGD_RST_REF 8'h01
`define CGD_RST_VCO_RANGE 8'h00
`define CGD_RST_VCO_LIN 8'h01
`define CGD_RST_ADC_CLK 8'h00
`define CGD_RST_CONFIG 8'h00

// nominal centre step of the vco, in Hz
`define CGD_F_NOM_HZ 38400
// good reference periods in a row before tracking and before lock
`define CGD_TRACK_RUN 4'h4
`define CGD_LOCK_RUN 4'h8
`define CGD_ADC_DIV_MAX 8'h10

`endif

// file: hdl/cgd_pkg.sv
// cgd_pkg.sv: types and shared decode of the clock generator.
// Assumes cgd_defs.svh is on the include path.
`include "cgd_defs.svh"
package cgd_pkg;
	typedef logic [`CGD_DATA_W-1:0] cgd_byte_type;
	typedef enum logic {CGD_FILTER_ACQ, CGD_FILTER_TRACK} cgd_filter_type;

	// power-of-two ratio, used for the vco prescaler and the adc prescaler
	function automatic cgd_byte_type cgd_pow2(input logic [2:0] p);
		cgd_pow2 = cgd_byte_type'(1) << p;
	endfunction
endpackage

// file: hdl/cgd_mod_div.sv
// cgd_mod_div.sv: modulo divider for a clock that is sampled as a level.
// Assumes tick_i marks each rising edge of lvl_i; a ratio of 0 or 1 passes
// the level through with one cycle of delay.
module cgd_mod_div #(
	parameter int W = 8
) (
	input logic clk,
	input logic rstn,
	input logic lvl_i,
	input logic tick_i,
	input logic [W-1:0] div_i,
	output logic clk_q,
	output logic rise_q
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic [W-1:0] half;
	logic clk_d;
	wire bypass = (div_i <= W'(1));
	wire wrap = (cnt_q >= div_i - W'(1));

	// high for the first half of each period, so odd ratios stay near 50%
	assign half = W'(({1'b0, div_i} + (W+1)'(1)) >> 1);
	assign cnt_d = (!tick_i || bypass) ? cnt_q :
		(wrap ? '0 : cnt_q + W'(1));
	assign clk_d = bypass ? lvl_i : (tick_i ? (cnt_d < half) : clk_q);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_q <= '0;
			clk_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			clk_q <= clk_d;
			rise_q <= clk_d & ~clk_q;
		end
	end

	property p_div_rise_tick;
		@(posedge clk) disable iff (!rstn)
		rise_q && !$past(bypass) |-> $past(tick_i);
	endproperty
	a_div_rise_tick: assert property (p_div_rise_tick)
		else $error("divided clock rose without an input edge");
endmodule

// file: hdl/cgd_clk_mux.sv
// cgd_clk_mux.sv: glitch-free selector between two sampled clock levels.
// Assumes both inputs come from flip-flops of the same clock domain.
module cgd_clk_mux (
	input logic clk,
	input logic rstn,
	input logic sel_i,
	input logic a_i,
	input logic b_i,
	output logic out_q,
	output logic cur_q
);
	logic park_q;
	logic park_d;
	logic cur_d;
	logic out_d;
	wire cur_src = cur_q ? b_i : a_i;
	wire new_src = sel_i ? b_i : a_i;

	// leave the old source only while it is low, join the new one only
	// while it is low: no pulse shorter than a half period of either
	assign park_d = park_q ? new_src : (sel_i != cur_q && !cur_src);
	assign cur_d = (park_q && !new_src) ? sel_i : cur_q;
	assign out_d = park_d ? 1'b0 : (cur_d ? b_i : a_i);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			park_q <= 1'b0;
			cur_q <= 1'b0;
			out_q <= 1'b0;
		end else begin
			park_q <= park_d;
			cur_q <= cur_d;
			out_q <= out_d;
		end
	end

	property p_mux_park_low;
		@(posedge clk) disable iff (!rstn)
		park_q |-> !out_q;
	endproperty
	a_mux_park_low: assert property (p_mux_park_low)
		else $error("selector output high while changing source");
endmodule

// file: hdl/cgd_clock_gen.sv
// cgd_clock_gen.sv: digital part of the clock generator with pll dividers,
// phase and lock detection, base and bus clock selection and the converter
// clock prescaler. Assumes crystal and vco clocks arrive as levels
// synchronous to CLK at well under half its rate; the loop filter and vco
// are analog and sit outside.
// Behaviour
// - Converter prescaler divides by 1, 2, 4, 8, or 16 when top bit set.
// - Converter input select 1 takes the bus clock, 0 the crystal clock.
// - After reset the converter prescaler takes the crystal clock.
// - Base clock is crystal or vco clock halved, chosen by software in user mode.
// - In user mode bus clock is half the base clock.
// - In monitor mode a port pin decides the bus clock source.
// - Oscillator runs when unit enable or stop-mode keep bit is set.
// - Pll reference clock is a buffered copy of the crystal clock.
// - Reference divider divides the reference clock by R.
// - Vco clock divided by 2^P then N gives the feedback clock.
// - Phase detector pulses up or down by the phase difference.
// - Lock detector compares frequencies to set filter mode and lock.
// - Vco centre is 38.4 kHz times L times 2^E.
// - Filter mode switches automatically or under software control.
// - An interrupt is raised on entering and on leaving lock.
// - Auto mode: flags are read-only; each lock toggle may interrupt.
// - Manual mode: writable mode bit, no lock, no interrupts.
`include "cgd_defs.svh"
module cgd_clock_gen
	import cgd_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input logic CLK,
	input logic RSTN,
	input logic [`CGD_ADDR_W-1:0] ADDR,
	input logic [`CGD_DATA_W-1:0] WDATA,
	input logic WR,
	input logic RD,
	output logic [`CGD_DATA_W-1:0] RDATA,
	input logic CRYSTAL_CLOCK,
	input logic VCO_CLOCK,
	input logic SIM_OSCILLATOR_ENABLE,
	input logic MONITOR_MODE,
	input logic MONITOR_CLOCK_SELECT_PIN,
	output logic OSC_ENABLE,
	output logic PLL_REFERENCE_CLOCK,
	output logic DIVIDED_REFERENCE_CLOCK,
	output logic VCO_FEEDBACK_CLOCK,
	output logic PUMP_UP,
	output logic PUMP_DOWN,
	output logic FILTER_TRACKING,
	output logic PLL_ON,
	output logic [1:0] VCO_RANGE_E,
	output logic [7:0] VCO_LINEAR,
	output logic [10:0] VCO_CENTER,
	output logic BASE_CLOCK_OUT,
	output logic BUS_CLOCK,
	output logic ADC_CLOCK,
	output logic PLL_IRQ
);
	// software state
	logic irq_en_q;
	logic irq_flag_q;
	logic irq_flag_d;
	logic pll_on_q;
	logic base_sel_q;
	logic [1:0] prescale_q;
	logic auto_q;
	logic acq_man_q;
	cgd_byte_type mult_q;
	cgd_byte_type ref_q;
	logic [1:0] range_e_q;
	cgd_byte_type lin_q;
	logic [2:0] adc_div_sel_q;
	logic adc_isel_q;
	logic osc_keep_q;
	cgd_byte_type rdata_q;
	// clock path state
	logic xtal_q;
	logic base_prev_q;
	logic adc_prev_q;
	logic osc_en_q;
	logic vco_q;
	logic [10:0] center_q;
	// detector state
	logic pump_up_q;
	logic pump_dn_q;
	logic [1:0] fb_cnt_q;
	logic [3:0] run_q;
	cgd_filter_type det_q;
	logic lock_q;
	logic filter_q;
	logic irq_q;
	// divider and selector outputs
	logic xtal_half;
	logic vco_half;
	logic ref_clk;
	logic ref_rise;
	logic pre_clk;
	logic pre_rise;
	logic fb_clk;
	logic fb_rise;
	logic base_clk;
	logic base_now;
	logic bus_user;
	logic bus_clk;
	logic adc_src;
	logic adc_now;
	logic adc_clk;

	// bus decode
	wire wr_ctrl = WR && ADDR == `CGD_OFS_PLL_CTRL;
	wire wr_bw = WR && ADDR == `CGD_OFS_PLL_BW;
	wire wr_mult = WR && ADDR == `CGD_OFS_PLL_MULT;
	wire wr_ref = WR && ADDR == `CGD_OFS_PLL_REF;
	wire wr_range = WR && ADDR == `CGD_OFS_VCO_RANGE;
	wire wr_lin = WR && ADDR == `CGD_OFS_VCO_LIN;
	wire wr_adc = WR && ADDR == `CGD_OFS_ADC_CLK;
	wire wr_cfg = WR && ADDR == `CGD_OFS_CONFIG;
	wire rd_ctrl = RD && ADDR == `CGD_OFS_PLL_CTRL;
	// edges of the sampled clocks
	wire xtal_rise = CRYSTAL_CLOCK & ~xtal_q;
	wire vco_q_rise = VCO_CLOCK & ~vco_q;
	wire base_rise = base_clk & ~base_prev_q;
	wire adc_rise = adc_src & ~adc_prev_q;
	// ratios
	wire [DIV_W-1:0] pre_div_w = DIV_W'(cgd_pow2({1'b0, prescale_q}));
	wire [DIV_W-1:0] adc_div_w = DIV_W'(adc_div_sel_q[2] ?
		`CGD_ADC_DIV_MAX : cgd_pow2({1'b0, adc_div_sel_q[1:0]}));
	// in monitor mode the base selector is held on the crystal and the pin
	// decides between the crystal itself and the normal halved path
	wire base_src_sel = base_sel_q && !MONITOR_MODE;
	wire bus_src_sel = MONITOR_MODE && MONITOR_CLOCK_SELECT_PIN;
	wire osc_en_d = SIM_OSCILLATOR_ENABLE || osc_keep_q;
	// lock detector: exactly one feedback edge per reference period is a
	// good period; any other count restarts the run
	wire period_good = (fb_cnt_q == 2'd1);
	wire [3:0] run_d = !pll_on_q ? 4'h0 :
		(!ref_rise ? run_q :
		(!period_good ? 4'h0 :
		(run_q == `CGD_LOCK_RUN ? run_q : run_q + 4'h1)));
	wire [1:0] fb_cnt_d = ref_rise ? {1'b0, fb_rise} :
		((fb_rise && fb_cnt_q != 2'd3) ? fb_cnt_q + 2'd1 : fb_cnt_q);
	cgd_filter_type det_d;
	assign det_d = (run_d >= `CGD_TRACK_RUN) ? CGD_FILTER_TRACK :
		CGD_FILTER_ACQ;
	// lock reads zero outside automatic mode
	wire lock_d = auto_q && (run_d >= `CGD_LOCK_RUN);
	wire lock_chg = auto_q && (lock_d != lock_q);
	wire filter_d = auto_q ? (det_d == CGD_FILTER_TRACK) :
		acq_man_q;
	// a toggle in the same cycle as the clearing read still sets the flag
	assign irq_flag_d = lock_chg || (irq_flag_q && !rd_ctrl);
	wire irq_d = irq_flag_d && irq_en_q && auto_q;
	// phase detector: up on a reference edge, down on a feedback edge,
	// both at once cancel
	wire pump_up_d = (ref_rise || pump_up_q) && !(fb_rise || pump_dn_q);
	wire pump_dn_d = (fb_rise || pump_dn_q) && !(ref_rise || pump_up_q);
	// read mux
	cgd_byte_type rd_word;
	always_comb begin
		rd_word = '0;
		unique case (ADDR)
			`CGD_OFS_PLL_CTRL: begin
				rd_word[`CGD_BIT_IRQ_EN] = irq_en_q;
				rd_word[`CGD_BIT_IRQ_FLAG] = irq_flag_q;
				rd_word[`CGD_BIT_PLL_ON] = pll_on_q;
				rd_word[`CGD_BIT_BASE_SEL] = base_sel_q;
				rd_word[`CGD_POS_PRESCALE+:2] = prescale_q;
			end
			`CGD_OFS_PLL_BW: begin
				rd_word[`CGD_BIT_AUTO] = auto_q;
				rd_word[`CGD_BIT_LOCK] = lock_q;
				rd_word[`CGD_BIT_ACQ] = auto_q ?
					(det_q == CGD_FILTER_TRACK) : acq_man_q;
			end
			`CGD_OFS_PLL_MULT: rd_word = mult_q;
			`CGD_OFS_PLL_REF: rd_word = ref_q;
			`CGD_OFS_VCO_RANGE: rd_word[1:0] = range_e_q;
			`CGD_OFS_VCO_LIN: rd_word = lin_q;
			`CGD_OFS_ADC_CLK: begin
				rd_word[`CGD_POS_ADC_DIV+:3] = adc_div_sel_q;
				rd_word[`CGD_BIT_ADC_ISEL] = adc_isel_q;
			end
			`CGD_OFS_CONFIG: begin
				rd_word[`CGD_BIT_OSC_KEEP] = osc_keep_q;
				rd_word[`CGD_BIT_ADC_SRC_NOW] = adc_now;
				rd_word[`CGD_BIT_BASE_SRC_NOW] = base_now;
			end
		endcase
	end

	// software registers
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			{irq_en_q, pll_on_q, base_sel_q, prescale_q} <= '0;
			auto_q <= 1'(`CGD_RST_PLL_BW >> `CGD_BIT_AUTO);
			{acq_man_q, osc_keep_q} <= '0;
			mult_q <= `CGD_RST_MULT;
			ref_q <= `CGD_RST_REF;
			range_e_q <= 2'(`CGD_RST_VCO_RANGE);
			lin_q <= `CGD_RST_VCO_LIN;
			adc_div_sel_q <= 3'(`CGD_RST_ADC_CLK >> `CGD_POS_ADC_DIV);
			adc_isel_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				irq_en_q <= WDATA[`CGD_BIT_IRQ_EN];
				pll_on_q <= WDATA[`CGD_BIT_PLL_ON];
				base_sel_q <= WDATA[`CGD_BIT_BASE_SEL];
				prescale_q <= WDATA[`CGD_POS_PRESCALE+:2];
			end
			if (wr_bw) begin
				auto_q <= WDATA[`CGD_BIT_AUTO];
				// the mode bit only takes writes in manual mode
				if (!WDATA[`CGD_BIT_AUTO] && !auto_q)
					acq_man_q <= WDATA[`CGD_BIT_ACQ];
			end
			if (wr_mult)
				mult_q <= WDATA;
			if (wr_ref)
				ref_q <= WDATA;
			if (wr_range)
				range_e_q <= WDATA[1:0];
			if (wr_lin)
				lin_q <= WDATA;
			if (wr_adc) begin
				adc_div_sel_q <= WDATA[`CGD_POS_ADC_DIV+:3];
				adc_isel_q <= WDATA[`CGD_BIT_ADC_ISEL];
			end
			if (wr_cfg)
				osc_keep_q <= WDATA[`CGD_BIT_OSC_KEEP];
		end
	end

	// clock path, detectors and read data
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			{xtal_q, vco_q, base_prev_q, adc_prev_q, osc_en_q} <= '0;
			{pump_up_q, pump_dn_q, lock_q, filter_q, irq_q} <= '0;
			{irq_flag_q, fb_cnt_q, run_q} <= '0;
			det_q <= CGD_FILTER_ACQ;
			{center_q, rdata_q} <= '0;
		end else begin
			xtal_q <= CRYSTAL_CLOCK;
			vco_q <= VCO_CLOCK;
			base_prev_q <= base_clk;
			adc_prev_q <= adc_src;
			osc_en_q <= osc_en_d;
			pump_up_q <= pump_up_d;
			pump_dn_q <= pump_dn_d;
			fb_cnt_q <= fb_cnt_d;
			run_q <= run_d;
			det_q <= det_d;
			lock_q <= lock_d;
			filter_q <= filter_d;
			irq_flag_q <= irq_flag_d;
			irq_q <= irq_d;
			// centre in units of the nominal step
			center_q <= 11'(lin_q) << range_e_q;
			rdata_q <= RD ? rd_word : '0;
		end
	end

	// dividers and selectors
	cgd_mod_div #(.W(DIV_W)) u_xtal_half (.clk(CLK), .rstn(RSTN),
		.lvl_i(CRYSTAL_CLOCK), .tick_i(xtal_rise), .div_i(DIV_W'(2)),
		.clk_q(xtal_half), .rise_q());
	cgd_mod_div #(.W(DIV_W)) u_vco_half (.clk(CLK), .rstn(RSTN),
		.lvl_i(VCO_CLOCK), .tick_i(vco_q_rise), .div_i(DIV_W'(2)),
		.clk_q(vco_half), .rise_q());
	cgd_mod_div #(.W(DIV_W)) u_ref_div (.clk(CLK), .rstn(RSTN),
		.lvl_i(CRYSTAL_CLOCK), .tick_i(xtal_rise), .div_i(ref_q),
		.clk_q(ref_clk), .rise_q(ref_rise));
	cgd_mod_div #(.W(DIV_W)) u_prescale (.clk(CLK), .rstn(RSTN),
		.lvl_i(VCO_CLOCK), .tick_i(vco_q_rise), .div_i(pre_div_w),
		.clk_q(pre_clk), .rise_q(pre_rise));
	cgd_mod_div #(.W(DIV_W)) u_fb_div (.clk(CLK), .rstn(RSTN),
		.lvl_i(pre_clk), .tick_i(pre_rise), .div_i(mult_q),
		.clk_q(fb_clk), .rise_q(fb_rise));
	cgd_clk_mux u_base_mux (.clk(CLK), .rstn(RSTN), .sel_i(base_src_sel),
		.a_i(xtal_half), .b_i(vco_half), .out_q(base_clk),
		.cur_q(base_now));
	cgd_mod_div #(.W(DIV_W)) u_bus_half (.clk(CLK), .rstn(RSTN),
		.lvl_i(base_clk), .tick_i(base_rise), .div_i(DIV_W'(2)),
		.clk_q(bus_user), .rise_q());
	cgd_clk_mux u_bus_mux (.clk(CLK), .rstn(RSTN), .sel_i(bus_src_sel),
		.a_i(bus_user), .b_i(xtal_q), .out_q(bus_clk), .cur_q());
	cgd_clk_mux u_adc_mux (.clk(CLK), .rstn(RSTN), .sel_i(adc_isel_q),
		.a_i(xtal_q), .b_i(bus_clk), .out_q(adc_src),
		.cur_q(adc_now));
	cgd_mod_div #(.W(DIV_W)) u_adc_div (.clk(CLK), .rstn(RSTN),
		.lvl_i(adc_src), .tick_i(adc_rise), .div_i(adc_div_w),
		.clk_q(adc_clk), .rise_q());

	// outputs, all from flip-flops
	assign RDATA = rdata_q;
	assign OSC_ENABLE = osc_en_q;
	assign PLL_REFERENCE_CLOCK = xtal_q;
	assign DIVIDED_REFERENCE_CLOCK = ref_clk;
	assign VCO_FEEDBACK_CLOCK = fb_clk;
	assign PUMP_UP = pump_up_q;
	assign PUMP_DOWN = pump_dn_q;
	assign FILTER_TRACKING = filter_q;
	assign PLL_ON = pll_on_q;
	assign VCO_RANGE_E = range_e_q;
	assign VCO_LINEAR = lin_q;
	assign VCO_CENTER = center_q;
	assign BASE_CLOCK_OUT = base_clk;
	assign BUS_CLOCK = bus_clk;
	assign ADC_CLOCK = adc_clk;
	assign PLL_IRQ = irq_q;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	property p_adc_div16;
		adc_div_sel_q[2] |-> adc_div_w == DIV_W'(16);
	endproperty
	a_adc_div16: assert property (p_adc_div16)
		else $error("converter prescaler not at sixteen");
	property p_adc_reset;
		$rose(RSTN) |-> !adc_isel_q && !adc_now;
	endproperty
	a_adc_reset: assert property (p_adc_reset)
		else $error("converter source not crystal after reset");
	property p_osc_en;
		1'b1 |=> OSC_ENABLE ==
			($past(SIM_OSCILLATOR_ENABLE) || $past(osc_keep_q));
	endproperty
	a_osc_en: assert property (p_osc_en)
		else $error("oscillator enable does not follow its sources");
	property p_ref_buf;
		$rose(CRYSTAL_CLOCK) |=> $rose(PLL_REFERENCE_CLOCK);
	endproperty
	a_ref_buf: assert property (p_ref_buf)
		else $error("reference clock lost a crystal edge");
	property p_pfd_excl;
		!(PUMP_UP && PUMP_DOWN);
	endproperty
	a_pfd_excl: assert property (p_pfd_excl)
		else $error("both correction pulses active");
	property p_pfd_up;
		ref_rise && !fb_rise && !pump_dn_q |=> PUMP_UP;
	endproperty
	a_pfd_up: assert property (p_pfd_up)
		else $error("reference edge gave no up pulse");
	property p_lock_irq;
		$changed(lock_q) && $past(irq_en_q) && $past(auto_q) |-> PLL_IRQ;
	endproperty
	a_lock_irq: assert property (p_lock_irq)
		else $error("lock toggle did not raise the interrupt");
	property p_manual_quiet;
		!auto_q |=> !lock_q && !PLL_IRQ;
	endproperty
	a_manual_quiet: assert property (p_manual_quiet)
		else $error("lock or interrupt active in manual mode");
	property p_filter_auto;
		auto_q && det_q == CGD_FILTER_TRACK && run_d != 4'h0
			|=> FILTER_TRACKING;
	endproperty
	a_filter_auto: assert property (p_filter_auto)
		else $error("filter not tracking in automatic mode");

	c_lock_rise: cover property ($rose(lock_q));
	c_irq: cover property ($rose(PLL_IRQ) ##[1:20] rd_ctrl);
	c_adc_bus: cover property ($rose(adc_now));
	c_manual_track: cover property (!auto_q && FILTER_TRACKING);
endmodule

// file: verif/cgd_osc_model.sv
// cgd_osc_model.sv: behavioural crystal and vco of the clock generator.
// Assumes the generator samples both as levels on clk; rates are set in
// cycles of clk by the bench and must stay at two or more per half period.
module cgd_osc_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic osc_en,
	input wire logic vco_en,
	input wire logic [7:0] xtal_half,
	input wire logic [7:0] vco_half,
	output logic xtal,
	output logic vco
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] xc;
	logic [7:0] vc;

	// crystal stands low while the amplifier is not enabled
	always @(posedge clk) begin
		if (!rstn || !osc_en) begin
			xc <= 8'h00;
			xtal <= 1'b0;
		end else if (xc >= xtal_half - 8'h01) begin
			xc <= 8'h00;
			xtal <= !xtal;
		end else begin
			xc <= xc + 8'h01;
		end
	end

	// vco only oscillates while the loop is switched on
	always @(posedge clk) begin
		if (!rstn || !vco_en) begin
			vc <= 8'h00;
			vco <= 1'b0;
		end else if (vc >= vco_half - 8'h01) begin
			vc <= 8'h00;
			vco <= !vco;
		end else begin
			vc <= vc + 8'h01;
		end
	end
endmodule

// file: verif/tb_top.sv
// tb_top.sv: self-checking bench of the clock generator.
// Assumes cgd_defs.svh on the include path and the oscillator model beside.
`include "cgd_defs.svh"
module tb_top
	import cgd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0, RSTN = 1'b0, WR, RD, SIM_OSCILLATOR_ENABLE;
	logic MONITOR_MODE, MONITOR_CLOCK_SELECT_PIN;
	logic [2:0] ADDR;
	logic [7:0] WDATA, RDATA, VCO_LINEAR, xh, vh;
	logic CRYSTAL_CLOCK, VCO_CLOCK, OSC_ENABLE, PLL_REFERENCE_CLOCK;
	logic DIVIDED_REFERENCE_CLOCK, VCO_FEEDBACK_CLOCK, PUMP_UP, PUMP_DOWN;
	logic FILTER_TRACKING, PLL_ON, BASE_CLOCK_OUT, BUS_CLOCK, ADC_CLOCK;
	logic PLL_IRQ;
	logic [1:0] VCO_RANGE_E;
	logic [10:0] VCO_CENTER;
	int errors = 0, n_compared = 0;
	logic [7:0] rst_val [8] = '{`CGD_RST_PLL_CTRL, `CGD_RST_PLL_BW,
		`CGD_RST_MULT, `CGD_RST_REF, `CGD_RST_VCO_RANGE, `CGD_RST_VCO_LIN,
		`CGD_RST_ADC_CLK, `CGD_RST_CONFIG};

	cgd_clock_gen #(.DIV_W(8)) i_dut (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.CRYSTAL_CLOCK(CRYSTAL_CLOCK), .VCO_CLOCK(VCO_CLOCK),
		.SIM_OSCILLATOR_ENABLE(SIM_OSCILLATOR_ENABLE),
		.MONITOR_MODE(MONITOR_MODE),
		.MONITOR_CLOCK_SELECT_PIN(MONITOR_CLOCK_SELECT_PIN),
		.OSC_ENABLE(OSC_ENABLE), .PLL_REFERENCE_CLOCK(PLL_REFERENCE_CLOCK),
		.DIVIDED_REFERENCE_CLOCK(DIVIDED_REFERENCE_CLOCK),
		.VCO_FEEDBACK_CLOCK(VCO_FEEDBACK_CLOCK), .PUMP_UP(PUMP_UP),
		.PUMP_DOWN(PUMP_DOWN), .FILTER_TRACKING(FILTER_TRACKING),
		.PLL_ON(PLL_ON), .VCO_RANGE_E(VCO_RANGE_E), .VCO_LINEAR(VCO_LINEAR),
		.VCO_CENTER(VCO_CENTER), .BASE_CLOCK_OUT(BASE_CLOCK_OUT),
		.BUS_CLOCK(BUS_CLOCK), .ADC_CLOCK(ADC_CLOCK), .PLL_IRQ(PLL_IRQ));

	cgd_osc_model i_osc (.clk(CLK), .rstn(RSTN), .osc_en(OSC_ENABLE),
		.vco_en(PLL_ON), .xtal_half(xh), .vco_half(vh),
		.xtal(CRYSTAL_CLOCK), .vco(VCO_CLOCK));

	always #5 CLK = ~CLK;

	task automatic chk(input logic [15:0] got, exp, input string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_per(input int got, exp, input string what);
		n_compared++;
		if (got != exp) begin
			errors++;
			$display("[FAIL] %0t %s period %0d exp %0d", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask

	function automatic logic pick(int s);
		case (s)
			0: pick = DIVIDED_REFERENCE_CLOCK;
			1: pick = VCO_FEEDBACK_CLOCK;
			2: pick = BASE_CLOCK_OUT;
			3: pick = BUS_CLOCK;
			default: pick = ADC_CLOCK;
		endcase
	endfunction

	// first rises are skipped: a selector switch may stretch them
	task automatic per(input int s, output int n);
		int k, c;
		logic p, v;
		k = 0;
		n = 0;
		p = 1'b1;
		for (c = 0; c < 4000 && k < 4; c++) begin
			@(posedge CLK);
			#1 v = pick(s);
			if (k == 3) n++;
			if (!p && v) k++;
			p = v;
		end
	endtask

	function automatic int adc_per(logic [2:0] c, logic isel);
		adc_per = (isel ? 8 * xh : 2 * xh) * (c[2] ? 16 : 1 << c[1:0]);
	endfunction

	task automatic done(input string t);
		$display("test %s done, mismatches so far %0d", t, errors);
	endtask

	task automatic report_and_stop;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge CLK);
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		report_and_stop;
	end

	initial begin
		int i, j, n, r, up, both;
		logic [7:0] d, w;
		xh = 8'h03;
		vh = 8'h03;
		ADDR = 3'h0;
		WDATA = 8'h00;
		WR = 1'b0;
		RD = 1'b0;
		SIM_OSCILLATOR_ENABLE = 1'b1;
		MONITOR_MODE = 1'b0;
		MONITOR_CLOCK_SELECT_PIN = 1'b0;
		void'($urandom(74203));
		repeat (16) @(posedge CLK);
		RSTN <= 1'b1;
		for (i = 0; i < 8; i++) begin
			rd(i[2:0], d);
			chk(d, rst_val[i], "reset value");
		end
		done("reset");
		for (i = 0; i < 3; i++) begin
			r = $urandom_range(1, 4);
			wr(`CGD_OFS_PLL_REF, r[7:0]);
			per(0, n);
			chk_per(n, 2 * xh * r, "ref divider");
			j = $urandom_range(0, 3);
			r = $urandom_range(1, 3);
			wr(`CGD_OFS_PLL_CTRL, 8'h20 | j[7:0]);
			wr(`CGD_OFS_PLL_MULT, r[7:0]);
			per(1, n);
			chk_per(n, 2 * vh * r * (1 << j), "feedback");
		end
		done("dividers");
		for (i = 0; i < 2; i++) begin
			wr(`CGD_OFS_PLL_CTRL, i ? 8'h30 : 8'h20);
			per(2, n);
			chk_per(n, i ? 4 * vh : 4 * xh, "base clock");
			per(3, n);
			chk_per(n, i ? 8 * vh : 8 * xh, "bus clock");
			rd(`CGD_OFS_CONFIG, d);
			chk(d[2], i[0], "base source");
		end
		MONITOR_MODE <= 1'b1;
		for (i = 0; i < 2; i++) begin
			MONITOR_CLOCK_SELECT_PIN <= i[0];
			per(3, n);
			chk_per(n, i ? 2 * xh : 8 * xh, "monitor bus");
		end
		MONITOR_MODE <= 1'b0;
		done("base and bus");
		wr(`CGD_OFS_PLL_CTRL, 8'h20);
		#1 chk(PLL_ON, 1'b1, "pll on");
		for (i = 0; i < 16; i++) begin
			w = {i[2:0], i[3], 4'h0};
			if (i[2]) w[6:5] = 2'($urandom_range(0, 3));
			wr(`CGD_OFS_ADC_CLK, w);
			rd(`CGD_OFS_ADC_CLK, d);
			chk(d & 8'hf0, w, "adc reg");
			per(4, n);
			chk_per(n, adc_per(w[7:5], i[3]), "adc clock");
			rd(`CGD_OFS_CONFIG, d);
			chk(d[1], i[3], "adc source");
		end
		done("converter clock");
		for (i = 0; i < 4; i++) begin
			SIM_OSCILLATOR_ENABLE <= i[0];
			wr(`CGD_OFS_CONFIG, {7'h00, i[1]});
			repeat (3) @(posedge CLK);
			#1 chk(OSC_ENABLE, i[0] | i[1], "osc enable");
		end
		SIM_OSCILLATOR_ENABLE <= 1'b1;
		wr(`CGD_OFS_CONFIG, 8'h00);
		repeat (20) @(posedge CLK);
		#1 d[0] = CRYSTAL_CLOCK;
		for (i = 0; i < 24; i++) begin
			@(posedge CLK);
			#1 chk(PLL_REFERENCE_CLOCK, d[0], "reference copy");
			d[0] = CRYSTAL_CLOCK;
		end
		for (i = 0; i < 4; i++) begin
			r = $urandom_range(1, 255);
			j = $urandom_range(0, 2);
			wr(`CGD_OFS_VCO_LIN, r[7:0]);
			wr(`CGD_OFS_VCO_RANGE, j[7:0]);
			repeat (3) @(posedge CLK);
			#1 chk(VCO_CENTER, 11'(r << j), "vco centre");
			chk(VCO_LINEAR, r[7:0], "vco linear");
			chk(VCO_RANGE_E, j[1:0], "vco range");
		end
		done("oscillator and reference");
		xh <= 8'h06;
		wr(`CGD_OFS_PLL_REF, 8'h01);
		wr(`CGD_OFS_PLL_MULT, 8'h02);
		wr(`CGD_OFS_PLL_CTRL, 8'h20);
		repeat (300) @(posedge CLK);
		#1 chk(FILTER_TRACKING, 1'b1, "tracking");
		rd(`CGD_OFS_PLL_BW, d);
		chk(d & 8'he0, 8'he0, "locked flags");
		wr(`CGD_OFS_PLL_CTRL, 8'ha0);
		repeat (2) @(posedge CLK);
		#1 chk(PLL_IRQ, 1'b1, "irq on lock");
		rd(`CGD_OFS_PLL_CTRL, d);
		chk(d[6], 1'b1, "irq flag");
		repeat (2) @(posedge CLK);
		#1 chk(PLL_IRQ, 1'b0, "irq cleared");
		vh <= 8'h04;
		up = 0;
		both = 0;
		for (i = 0; i < 300; i++) begin
			@(posedge CLK);
			#1 up += PUMP_UP | PUMP_DOWN;
			both += PUMP_UP & PUMP_DOWN;
		end
		chk(both != 0, 1'b0, "pumps together");
		chk(up > 0, 1'b1, "pump pulses");
		chk(PLL_IRQ, 1'b1, "irq on unlock");
		rd(`CGD_OFS_PLL_BW, d);
		chk(d[6], 1'b0, "lock lost");
		wr(`CGD_OFS_PLL_BW, 8'h00);
		wr(`CGD_OFS_PLL_BW, 8'h20);
		repeat (2) @(posedge CLK);
		#1 chk(FILTER_TRACKING, 1'b1, "manual track");
		chk(PLL_IRQ, 1'b0, "manual irq");
		rd(`CGD_OFS_PLL_BW, d);
		chk(d & 8'he0, 8'h20, "manual flags");
		wr(`CGD_OFS_PLL_BW, 8'h00);
		repeat (2) @(posedge CLK);
		#1 chk(FILTER_TRACKING, 1'b0, "manual acquire");
		done("loop control");
		report_and_stop;
	end
endmodule
